// ---- periodic_irq_timer.sv ----
`timescale 1ns/10ps
// Functional notes
// - Sixteen-bit up-counter, free-running or counting up to the wrap limit.
// - Reading the count never disturbs counting.
// - Select codes 0..6 divide bus clock by 1..64; code 7 also 64; reset clears.
// - Overflow flag sets when count wraps from wrap limit to zero; reset clears it.
// - Flag clears by status read with flag set, then writing zero.
// - Overflow between read and zero write keeps flag set.
// - Writing one to the flag leaves it unchanged.
// - Interrupt request raised only while flag and enable both set; reset clears enable.
// - Halt bit freezes counter; reset sets it, so counter starts halted.
// - Counter clear bit zeroes counter and prescaler, self-clears, reads zero.
// - Halt and clear written together leave counter stopped at zero.
// - Wait mode keeps counting, refuses bus access, enabled request still wakes.
// - Stop mode freezes timer, keeps all state, resumes afterwards.
// - Break state halts the counter.
// - With break clear enable high, flags clear in break and stay cleared.
// - With it low, break accesses leave flags; earlier first step stays armed.
// - After reaching wrap limit, counting restarts from zero next timer tick.
// - High byte read latches low byte until low byte is read.
// - Wrap high write suppresses flag setting until wrap low is written.
module periodic_irq_timer (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [pit_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [pit_pkg::DATA_W-1:0] i_wdata,
	input wire logic [pit_pkg::STRB_W-1:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [pit_pkg::ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [pit_pkg::DATA_W-1:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_wait_mode,
	input wire logic i_stop_mode,
	input wire logic i_break_state,
	input wire logic i_break_clear_enable,
	output logic o_irq
);
	import pit_pkg::*;

	// ==========================================================
	// Declarations
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_lane0;
	logic wr_err;
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [7:0] rd_data;
	logic rd_err;

	logic overflow_flag_q;
	logic overflow_flag_d;
	logic overflow_irq_enable_q;
	logic counter_halt_q;
	logic [2:0] prescale_select_q;
	logic clear_armed_q;
	logic clear_armed_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [15:0] wrap_limit_q;
	logic wrap_pending_q;
	logic [7:0] low_buf_q;
	logic low_latched_q;

	logic run;
	logic tick;
	logic at_limit;
	logic wrap_event;
	logic set_flag;
	logic protect;
	logic acc_ok;
	logic wr_status;
	logic wr_wrap_hi;
	logic wr_wrap_lo;
	logic rd_status;
	logic rd_count_hi;
	logic rd_count_lo;
	logic counter_clear;
	logic flag_zero_write;
	logic [7:0] status_view;

	// ==========================================================
	// Address decode
	function automatic logic known_addr(input logic [ADDR_W-1:0] a);
		known_addr = (a == ADDR_STATUS) || (a == ADDR_COUNT_HI) || (a == ADDR_COUNT_LO)
			|| (a == ADDR_WRAP_HI) || (a == ADDR_WRAP_LO);
	endfunction : known_addr

	assign acc_ok = !i_wait_mode;
	assign wr_err = !acc_ok || !known_addr(wr_addr);
	assign rd_err = !acc_ok || !known_addr(rd_addr);

	// Byte lane 0 carries the register; other lanes are dropped
	assign wr_status = wr_en && !wr_err && wr_lane0 && (wr_addr == ADDR_STATUS);
	assign wr_wrap_hi = wr_en && !wr_err && wr_lane0 && (wr_addr == ADDR_WRAP_HI);
	assign wr_wrap_lo = wr_en && !wr_err && wr_lane0 && (wr_addr == ADDR_WRAP_LO);
	assign rd_status = rd_en && !rd_err && (rd_addr == ADDR_STATUS);
	assign rd_count_hi = rd_en && !rd_err && (rd_addr == ADDR_COUNT_HI);
	assign rd_count_lo = rd_en && !rd_err && (rd_addr == ADDR_COUNT_LO);

	// ==========================================================
	// Bus slave
	pit_axil_slave u_bus (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_araddr(i_araddr),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.o_wr_en(wr_en),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data),
		.o_wr_lane0(wr_lane0),
		.i_wr_err(wr_err),
		.o_rd_en(rd_en),
		.o_rd_addr(rd_addr),
		.i_rd_data(rd_data),
		.i_rd_err(rd_err)
	);

	// ==========================================================
	// Run gating
	// Halt freezes count
	assign run = !counter_halt_q && !i_stop_mode && !i_break_state;

	assign counter_clear = wr_status && wr_data[BIT_CLEAR];

	pit_prescaler u_presc (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(run),
		.i_clear(counter_clear),
		.i_sel(prescale_select_q),
		.o_tick(tick)
	);

	// ==========================================================
	// Counter
	// Full width compare
	assign at_limit = (count_q == wrap_limit_q);
	assign wrap_event = tick && at_limit;

	assign count_d = counter_clear ? COUNT_RESET
		: (wrap_event ? COUNT_RESET : (tick ? count_q + 16'h0001 : count_q));

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count_q <= COUNT_RESET;
		end else begin
			count_q <= count_d;
		end
	end

	// ==========================================================
	// Overflow flag
	// Set on wrapping from limit
	assign set_flag = wrap_event && !wrap_pending_q;

	// Break without clear enable freezes the two-step sequence
	// Break clear blocked
	assign protect = i_break_state && !i_break_clear_enable;

	assign flag_zero_write = wr_status && !wr_data[BIT_FLAG] && clear_armed_q && !protect;

	assign overflow_flag_d = set_flag ? 1'b1 : (flag_zero_write ? 1'b0 : overflow_flag_q);

	// A fresh overflow disarms, so a stale read cannot clear it
	always_comb begin
		clear_armed_d = clear_armed_q;
		if (flag_zero_write) begin
			clear_armed_d = 1'b0;
		end
		if (rd_status && overflow_flag_q && !protect) begin
			clear_armed_d = 1'b1;
		end
		if (set_flag) begin
			clear_armed_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			overflow_flag_q <= STATUS_RESET[BIT_FLAG];
			clear_armed_q <= 1'b0;
		end else begin
			overflow_flag_q <= overflow_flag_d;
			clear_armed_q <= clear_armed_d;
		end
	end

	// ==========================================================
	// Control fields
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			overflow_irq_enable_q <= STATUS_RESET[BIT_IRQ_EN];
			counter_halt_q <= STATUS_RESET[BIT_HALT];
			prescale_select_q <= SEL_RESET;
		end else if (wr_status) begin
			overflow_irq_enable_q <= wr_data[BIT_IRQ_EN];
			counter_halt_q <= wr_data[BIT_HALT];
			prescale_select_q <= wr_data[SEL_HI:SEL_LO];
		end
	end

	assign o_irq = overflow_flag_q && overflow_irq_enable_q;

	// ==========================================================
	// Wrap limit
	// High write arms pending
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wrap_limit_q <= WRAP_RESET;
			wrap_pending_q <= 1'b0;
		end else begin
			if (wr_wrap_hi) begin
				wrap_limit_q[15:8] <= wr_data;
				wrap_pending_q <= 1'b1;
			end
			if (wr_wrap_lo) begin
				wrap_limit_q[7:0] <= wr_data;
				wrap_pending_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Count readback
	// High read latches low
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			low_buf_q <= COUNT_RESET[7:0];
			low_latched_q <= 1'b0;
		end else if (rd_count_lo) begin
			low_latched_q <= 1'b0;
		end else if (rd_count_hi && !low_latched_q) begin
			low_buf_q <= count_q[7:0];
			low_latched_q <= 1'b1;
		end
	end

	assign status_view = {overflow_flag_q, overflow_irq_enable_q, counter_halt_q, 2'b00, prescale_select_q};

	// Unlatched low read returns the live byte
	assign rd_data = rd_err ? 8'h00
		: (rd_addr == ADDR_STATUS) ? status_view
		: (rd_addr == ADDR_COUNT_HI) ? count_q[15:8]
		: (rd_addr == ADDR_COUNT_LO) ? (low_latched_q ? low_buf_q : count_q[7:0])
		: (rd_addr == ADDR_WRAP_HI) ? wrap_limit_q[15:8]
		: wrap_limit_q[7:0];
endmodule : periodic_irq_timer

// ---- pit_pkg.sv ----
package pit_pkg;
	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_STATUS = 8'h4B;
	localparam logic [7:0] IDX_COUNT_HI = 8'h4C;
	localparam logic [7:0] IDX_COUNT_LO = 8'h4D;
	localparam logic [7:0] IDX_WRAP_HI = 8'h4E;
	localparam logic [7:0] IDX_WRAP_LO = 8'h4F;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_COUNT_HI = {2'b00, IDX_COUNT_HI, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_COUNT_LO = {2'b00, IDX_COUNT_LO, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_WRAP_HI = {2'b00, IDX_WRAP_HI, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_WRAP_LO = {2'b00, IDX_WRAP_LO, 2'b00};

	// ==========================================================
	// Status and control field positions
	localparam int BIT_FLAG = 7;
	localparam int BIT_IRQ_EN = 6;
	localparam int BIT_HALT = 5;
	localparam int BIT_CLEAR = 4;
	localparam int SEL_HI = 2;
	localparam int SEL_LO = 0;

	// ==========================================================
	// Values after reset
	localparam logic [7:0] STATUS_RESET = 8'h20;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] WRAP_RESET = 16'hFFFF;
	localparam logic [2:0] SEL_RESET = 3'h0;

	// ==========================================================
	// Prescaler and bus answers
	localparam int PRESC_W = 6;
	localparam logic [2:0] SEL_MAX = 3'h6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pit_pkg

// ---- pit_prescaler.sv ----
`timescale 1ns/10ps
module pit_prescaler (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_run,
	input wire logic i_clear,
	input wire logic [2:0] i_sel,
	output logic o_tick
);
	import pit_pkg::*;

	logic [PRESC_W-1:0] div_q;
	logic [PRESC_W-1:0] div_d;
	logic [PRESC_W-1:0] mask;
	logic [2:0] sel_eff;

	// ==========================================================
	// Tap selection
	function automatic logic [PRESC_W-1:0] tap_mask(input logic [2:0] sel);
		logic [PRESC_W:0] one_hot;
		one_hot = (PRESC_W + 1)'(1) << sel;
		tap_mask = one_hot[PRESC_W-1:0] - PRESC_W'(1);
	endfunction : tap_mask

	assign sel_eff = (i_sel > SEL_MAX) ? SEL_MAX : i_sel;
	assign mask = tap_mask(sel_eff);
	assign o_tick = i_run && !i_clear && ((div_q & mask) == mask);
	assign div_d = i_clear ? '0 : (i_run ? div_q + PRESC_W'(1) : div_q);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end
endmodule : pit_prescaler

// ---- pit_axil_slave.sv ----
`timescale 1ns/10ps
module pit_axil_slave (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [pit_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [pit_pkg::DATA_W-1:0] i_wdata,
	input wire logic [pit_pkg::STRB_W-1:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [pit_pkg::ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [pit_pkg::DATA_W-1:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_wr_en,
	output logic [pit_pkg::ADDR_W-1:0] o_wr_addr,
	output logic [7:0] o_wr_data,
	output logic o_wr_lane0,
	input wire logic i_wr_err,
	output logic o_rd_en,
	output logic [pit_pkg::ADDR_W-1:0] o_rd_addr,
	input wire logic [7:0] i_rd_data,
	input wire logic i_rd_err
);
	import pit_pkg::*;

	logic aw_got_q;
	logic w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0] wdata_q;
	logic lane0_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [DATA_W-1:0] rdata_q;

	// ==========================================================
	// Handshakes, one write and one read in flight
	assign o_awready = !aw_got_q && !bvalid_q;
	assign o_wready = !w_got_q && !bvalid_q;
	assign o_wr_en = aw_got_q && w_got_q && !bvalid_q;
	assign o_wr_addr = awaddr_q;
	assign o_wr_data = wdata_q;
	assign o_wr_lane0 = lane0_q;
	assign o_arready = !rvalid_q;
	assign o_rd_en = i_arvalid && !rvalid_q;
	assign o_rd_addr = i_araddr;
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;
	assign o_rvalid = rvalid_q;
	assign o_rresp = rresp_q;
	assign o_rdata = rdata_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			lane0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= i_wdata[7:0];
				lane0_q <= i_wstrb[0];
			end
			if (o_wr_en) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= i_wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (bvalid_q && i_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
		end else if (o_rd_en) begin
			rvalid_q <= 1'b1;
			rresp_q <= i_rd_err ? RESP_SLVERR : RESP_OKAY;
			rdata_q <= {24'h000000, i_rd_data};
		end else if (rvalid_q && i_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule : pit_axil_slave

// ---- periodic_irq_timer_asserts.sv ----
`timescale 1ns/10ps
module periodic_irq_timer_asserts
import pit_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic [pit_pkg::ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [pit_pkg::DATA_W-1:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_wait_mode
);
	// ==========================================================
	// Bus answer checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_ar;
		i_arvalid && o_arready;
	endsequence
	sequence s_stat;
		s_ar ##0 (i_araddr == ADDR_STATUS) ##0 !i_wait_mode;
	endsequence
	sequence s_wboth;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write answer dropped early");
	AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read answer dropped early");
	AST_W_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write taken while answer pending");
	AST_AR_BLOCK: assert property (o_rvalid |-> !o_arready)
		else $error("read taken while answer pending");
	AST_R_ANS: assert property (s_ar |=> o_rvalid && o_rdata[31:8] == 24'h000000)
		else $error("read answer late or wide");
	AST_WAIT_REFUSE: assert property (s_ar ##0 i_wait_mode |=> o_rresp == RESP_SLVERR)
		else $error("read in wait mode accepted");
	AST_STAT_ZERO: assert property (s_stat |=> o_rdata[4:3] == 2'b00 && o_rresp == RESP_OKAY)
		else $error("status clear bit not zero");
	AST_W_ANS: assert property (s_wboth |=> !o_bvalid ##1 o_bvalid)
		else $error("write answer timing wrong");
endmodule : periodic_irq_timer_asserts
bind periodic_irq_timer periodic_irq_timer_asserts periodic_irq_timer_asserts_inst (.i_clk, .i_rst,
	.i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
	.i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_wait_mode);

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
	import pit_pkg::*;
	logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic i_wait_mode, i_stop_mode, i_break_state, i_break_clear_enable;
	logic [ADDR_W-1:0] i_awaddr, i_araddr;
	logic [DATA_W-1:0] i_wdata, o_rdata;
	logic [STRB_W-1:0] i_wstrb;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
	logic [1:0] o_bresp, o_rresp, r;
	logic [15:0] c1, c2;
	logic [7:0] v;
	int mismatches = 0;
	int check_count = 0;
	int s, d;
	periodic_irq_timer periodic_irq_timer_inst (.i_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready,
		.i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
		.i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_wait_mode,
		.i_stop_mode, .i_break_state, .i_break_clear_enable, .o_irq);
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// ==========================================================
	// Tasks
	task conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Bounded waits only, a hang ends the run
	task tmo(input int n);
		if (n > 300) begin
			chk(32'h0, 32'h1);
			conclude();
		end
	endtask : tmo
	task wr(input logic [11:0] a, input logic [7:0] dt, input logic [1:0] er);
		int n;
		logic aa, wa, ba;
		n = 0;
		ba = 1'b0;
		i_awaddr <= a;
		i_wdata <= {24'h000000, dt};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		while (!ba) begin
			@(negedge i_clk);
			aa = i_awvalid && o_awready;
			wa = i_wvalid && o_wready;
			ba = o_bvalid;
			r = o_bresp;
			@(posedge i_clk);
			if (aa) i_awvalid <= 1'b0;
			if (wa) i_wvalid <= 1'b0;
			n++;
			tmo(n);
		end
		chk(r, er);
	endtask : wr
	task rd(input logic [11:0] a, output logic [7:0] q);
		int n;
		logic aa, ra;
		n = 0;
		ra = 1'b0;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		while (!ra) begin
			@(negedge i_clk);
			aa = i_arvalid && o_arready;
			ra = o_rvalid;
			q = o_rdata[7:0];
			r = o_rresp;
			@(posedge i_clk);
			if (aa) i_arvalid <= 1'b0;
			n++;
			tmo(n);
		end
	endtask : rd
	task rc(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
		rd(a, v);
		chk(v, ed);
		chk(r, er);
	endtask : rc
	task cnt(output logic [15:0] q);
		rd(ADDR_COUNT_HI, q[15:8]);
		rd(ADDR_COUNT_LO, q[7:0]);
	endtask : cnt
	task wirq;
		int n;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
			tmo(n);
		end while (o_irq !== 1'b1);
		@(posedge i_clk);
	endtask : wirq
	// ==========================================================
	// Sequence
	initial begin
		// Answer readies held high, so no same-step re-raise between calls
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h05;
		{i_wait_mode, i_stop_mode, i_break_state, i_break_clear_enable} = 4'h0;
		i_awaddr = '0;
		i_araddr = '0;
		i_wdata = '0;
		i_wstrb = 4'hF;
		i_rst = 1'b1;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		rc(ADDR_STATUS, STATUS_RESET, RESP_OKAY);
		rc(ADDR_WRAP_HI, 8'hFF, RESP_OKAY);
		rc(ADDR_WRAP_LO, 8'hFF, RESP_OKAY);
		rc(12'h000, 8'h00, RESP_SLVERR);
		wr(12'h000, 8'h00, RESP_SLVERR);
		chk(o_irq, 1'b0);
		repeat (20) @(posedge i_clk);
		rc(ADDR_COUNT_LO, 8'h00, RESP_OKAY);
		for (s = 0; s < 8; s++) begin
			wr(ADDR_STATUS, {5'h06, s[2:0]}, RESP_OKAY);
			rc(ADDR_STATUS, {5'h04, s[2:0]}, RESP_OKAY);
			cnt(c1);
			chk(c1, 16'h0000);
			wr(ADDR_STATUS, {5'h00, s[2:0]}, RESP_OKAY);
			repeat (640) @(posedge i_clk);
			wr(ADDR_STATUS, {5'h04, s[2:0]}, RESP_OKAY);
			cnt(c1);
			d = (s == 7) ? 64 : (1 << s);
			chk(c1 >= 640 / d && c1 <= 650 / d + 1, 1'b1);
		end
		rd(ADDR_COUNT_HI, v);
		wr(ADDR_STATUS, 8'h30, RESP_OKAY);
		rc(ADDR_COUNT_LO, c1[7:0], RESP_OKAY);
		rc(ADDR_COUNT_LO, 8'h00, RESP_OKAY);
		wr(ADDR_STATUS, 8'h00, RESP_OKAY);
		i_break_state <= 1'b1;
		cnt(c1);
		cnt(c2);
		chk(c2, c1);
		i_break_state <= 1'b0;
		i_stop_mode <= 1'b1;
		cnt(c1);
		cnt(c2);
		chk(c2, c1);
		i_stop_mode <= 1'b0;
		i_wait_mode <= 1'b1;
		rd(ADDR_STATUS, v);
		chk(r, RESP_SLVERR);
		wr(ADDR_STATUS, 8'h20, RESP_SLVERR);
		// Let the count run in wait long enough to be seen
		repeat (16) @(posedge i_clk);
		i_wait_mode <= 1'b0;
		cnt(c2);
		chk(c2 - c1 > 16'd12, 1'b1);
		rc(ADDR_STATUS, 8'h00, RESP_OKAY);
		wr(ADDR_STATUS, 8'h30, RESP_OKAY);
		wr(ADDR_WRAP_HI, 8'h00, RESP_OKAY);
		wr(ADDR_WRAP_LO, 8'h05, RESP_OKAY);
		wr(ADDR_STATUS, 8'h40, RESP_OKAY);
		wirq();
		wr(ADDR_STATUS, 8'hE0, RESP_OKAY);
		chk(o_irq, 1'b1);
		wr(ADDR_STATUS, 8'h60, RESP_OKAY);
		chk(o_irq, 1'b1);
		rc(ADDR_STATUS, 8'hE0, RESP_OKAY);
		wr(ADDR_STATUS, 8'h60, RESP_OKAY);
		chk(o_irq, 1'b0);
		cnt(c1);
		chk(c1 <= 16'h0005, 1'b1);
		wr(ADDR_STATUS, 8'h40, RESP_OKAY);
		wirq();
		rd(ADDR_STATUS, v);
		repeat (8) @(posedge i_clk);
		wr(ADDR_STATUS, 8'h60, RESP_OKAY);
		chk(o_irq, 1'b1);
		rd(ADDR_STATUS, v);
		i_break_state <= 1'b1;
		wr(ADDR_STATUS, 8'h60, RESP_OKAY);
		chk(o_irq, 1'b1);
		i_break_state <= 1'b0;
		wr(ADDR_STATUS, 8'h60, RESP_OKAY);
		chk(o_irq, 1'b0);
		wr(ADDR_STATUS, 8'h40, RESP_OKAY);
		wirq();
		wr(ADDR_STATUS, 8'h60, RESP_OKAY);
		i_break_state <= 1'b1;
		i_break_clear_enable <= 1'b1;
		rd(ADDR_STATUS, v);
		wr(ADDR_STATUS, 8'h60, RESP_OKAY);
		i_break_state <= 1'b0;
		rc(ADDR_STATUS, 8'h60, RESP_OKAY);
		wr(ADDR_STATUS, 8'h70, RESP_OKAY);
		wr(ADDR_WRAP_HI, 8'h00, RESP_OKAY);
		wr(ADDR_STATUS, 8'h40, RESP_OKAY);
		repeat (40) @(posedge i_clk);
		chk(o_irq, 1'b0);
		wr(ADDR_WRAP_LO, 8'h05, RESP_OKAY);
		wirq();
		conclude();
	end
endmodule : testbench
